/* File: hw/upsc_ctrl_regs.v */
// control, timing and mode register group of the connector interface switch
// assumes a serial-bus front end giving byte accesses with one-cycle strobes
//
// Overview of operation
// - power switch follows control bit 1
// - power bit resets to bus-voltage presence
// - writing one to bit 2 soft-resets chip
// - reset done clears request, sets flag
// - auto low-power on: ignore host entry
// - auto off: host may enter low power
// - bit 6 joins speaker to data-minus
// - test registers reachable only with bit 7
// - identify waits (code+1) times 100 ms
// - idle (code+1) seconds enters low power
// - mode bit 0 flags reset, reads one
// - reading mode register clears reset flag
// - mode bit 1 active, resets zero
// - mode bit 2 low power, resets zero
// - status bit reflects real switch state
`timescale 1ns/1ps
`include "upsc_map.vh"
module upsc_ctrl_regs #(
	parameter TD_STEP_CYCLES   = `UPSC_TD_STEP_MS * `UPSC_CLK_KHZ,
	parameter IDLE_STEP_CYCLES = `UPSC_IDLE_STEP_MS * `UPSC_CLK_KHZ
) (
	input  wire       clk,
	input  wire       rst_b,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata_ff,
	output wire       test_sel,
	input  wire [7:0] test_rdata,
	input  wire       bus_voltage_present,
	input  wire       switch_activity,
	input  wire       audio_tty_attached,
	input  wire       power_switch_sense,
	output wire       power_switch_on,
	output wire       left_speaker_to_dminus_switch,
	output wire       chip_soft_reset,
	output wire       identify_start,
	output wire       low_power_state
);
////////////////////////////////////////////////////////////////////////////////
reg  [7:0] chip_control_ff;
reg  [7:0] timing_delay_config_ff;
reg        reset_seen_ff;
reg        active_ff;
reg        low_power_ff;
reg  [3:0] srst_cnt_ff;
reg        vbus_q_ff;
reg        idle_armed_ff;
reg  [7:0] nxt_rdata;
wire       td_done;
wire       idle_done;
wire       vbus_rise;
wire       idle_start;
wire       idle_stop;

// one decoder for the write and mode-read byte address compares
function addr_is;
	input [7:0] a;
	input [7:0] off;
	begin
		addr_is = (a == off);
	end
endfunction

function is_test_addr;
	input [7:0] a;
	begin
		is_test_addr = (a >= `UPSC_OFF_TEST_LO) && (a <= `UPSC_OFF_TEST_HI);
	end
endfunction

wire wr_ctrl   = reg_wr && addr_is(reg_addr, `UPSC_OFF_CHIP_CTRL);
wire wr_timing = reg_wr && addr_is(reg_addr, `UPSC_OFF_TIMING);
wire wr_mode   = reg_wr && addr_is(reg_addr, `UPSC_OFF_MODE);
wire rd_mode   = reg_rd && addr_is(reg_addr, `UPSC_OFF_MODE);
wire srst_act  = (srst_cnt_ff != 4'h0);
wire auto_lp   = chip_control_ff[`UPSC_CTRL_AUTO_BIT];
// soft reset acts as a local reset of this group; bus writes ignored meanwhile, reads still answered
wire grp_rst   = !rst_b || srst_act;

////////////////////////////////////////////////////////////////////////////////
// soft reset sequencer; a write of zero to bit 2 does nothing
always @(posedge clk)
begin
	if (!rst_b)
		srst_cnt_ff <= 4'h0;
	else if (srst_act)
		srst_cnt_ff <= srst_cnt_ff - 4'h1;
	else if (wr_ctrl && reg_wdata[`UPSC_CTRL_SRST_BIT])
		srst_cnt_ff <= `UPSC_SRST_CYCLES;
end
assign chip_soft_reset = srst_act;

////////////////////////////////////////////////////////////////////////////////
// bus voltage edge shared by the power bit and the identify delay;
// cleared in reset so a supply already present counts as a fresh rise
always @(posedge clk)
begin
	if (grp_rst)
		vbus_q_ff <= 1'b0;
	else
		vbus_q_ff <= bus_voltage_present;
end
assign vbus_rise = bus_voltage_present && !vbus_q_ff;

always @(posedge clk)
begin
	if (grp_rst)
	begin
		chip_control_ff                     <= `UPSC_CTRL_RESET;
		chip_control_ff[`UPSC_CTRL_PWR_BIT] <= bus_voltage_present;
		timing_delay_config_ff              <= `UPSC_TIMING_RESET;
	end
	else
	begin
		if (wr_ctrl)
			chip_control_ff <= reg_wdata & `UPSC_CTRL_RW_MASK;
		// a supply rise in the write cycle still turns the switch on
		if (vbus_rise)
			chip_control_ff[`UPSC_CTRL_PWR_BIT] <= 1'b1;
		if (wr_timing)
			timing_delay_config_ff <= reg_wdata;
	end
end

assign power_switch_on = chip_control_ff[`UPSC_CTRL_PWR_BIT];
assign left_speaker_to_dminus_switch = chip_control_ff[`UPSC_CTRL_SPK_BIT];

////////////////////////////////////////////////////////////////////////////////
// mode register; a reset flag set during soft reset beats a read clear
always @(posedge clk)
begin
	if (!rst_b || srst_act)
	begin
		reset_seen_ff <= 1'b1;
		active_ff     <= 1'b0;
		low_power_ff  <= 1'b0;
	end
	else
	begin
		if (rd_mode)
			reset_seen_ff <= 1'b0;
		if (wr_mode)
			active_ff <= reg_wdata[`UPSC_MODE_ACT_BIT];
		if (idle_done && auto_lp)
			low_power_ff <= 1'b1;
		else if (wr_mode && (!auto_lp || !reg_wdata[`UPSC_MODE_LP_BIT]))
			low_power_ff <= reg_wdata[`UPSC_MODE_LP_BIT];
		// activity wakes the block only under automatic control
		else if (switch_activity && auto_lp)
			low_power_ff <= 1'b0;
	end
end
assign low_power_state = low_power_ff;

////////////////////////////////////////////////////////////////////////////////
upsc_delay_timer #(
	.STEP_CYCLES (TD_STEP_CYCLES)
) u_td_timer (
	.clk     (clk),
	.rst_b   (!grp_rst),
	.start   (vbus_rise),
	.stop    (!bus_voltage_present),
	.code    (timing_delay_config_ff[3:0]),
	.done_ff (td_done)
);
assign identify_start = td_done;

// idle count armed whenever attached, automatic entry is allowed and low power is off;
// any switch event restarts it, so only true silence reaches the limit
always @(posedge clk)
begin
	if (grp_rst || idle_stop)
		idle_armed_ff <= 1'b0;
	else
		idle_armed_ff <= 1'b1;
end
assign idle_stop  = !audio_tty_attached || !auto_lp || low_power_ff;
assign idle_start = switch_activity || (!idle_stop && !idle_armed_ff);

upsc_delay_timer #(
	.STEP_CYCLES (IDLE_STEP_CYCLES)
) u_idle_timer (
	.clk     (clk),
	.rst_b   (!grp_rst),
	.start   (idle_start),
	.stop    (idle_stop),
	.code    (timing_delay_config_ff[7:4]),
	.done_ff (idle_done)
);

////////////////////////////////////////////////////////////////////////////////
// window gated here so a locked test byte never reaches the bus
assign test_sel = is_test_addr(reg_addr) && chip_control_ff[`UPSC_CTRL_TEST_BIT];

// unmapped addresses and a locked test window read as zero
always @*
begin
	nxt_rdata = 8'h00;
	case (reg_addr)
		`UPSC_OFF_CHIP_CTRL: nxt_rdata = chip_control_ff;
		`UPSC_OFF_TIMING:    nxt_rdata = timing_delay_config_ff;
		`UPSC_OFF_MODE:      nxt_rdata = {5'h00, low_power_ff, active_ff, reset_seen_ff};
		`UPSC_OFF_STATUS:    nxt_rdata = {1'b0, power_switch_sense, 6'h00};
		default:
			if (test_sel)
				nxt_rdata = test_rdata;
	endcase
end

always @(posedge clk)
begin
	if (!rst_b)
		reg_rdata_ff <= 8'h00;
	else if (reg_rd)
		reg_rdata_ff <= nxt_rdata;
end
endmodule // upsc_ctrl_regs

/* File: hw/upsc_map.vh */
// register map constants for the port switch control and mode register group
// assumes inclusion by the design files only; no process here
`ifndef UPSC_MAP_VH
`define UPSC_MAP_VH
`define UPSC_ADDR_W            8
`define UPSC_OFF_CHIP_CTRL     8'h00
`define UPSC_OFF_TIMING        8'h01
`define UPSC_OFF_MODE          8'h02
`define UPSC_OFF_STATUS        8'h03
`define UPSC_OFF_TEST_LO       8'h24
`define UPSC_OFF_TEST_HI       8'h26
`define UPSC_CTRL_PWR_BIT      1
`define UPSC_CTRL_SRST_BIT     2
`define UPSC_CTRL_AUTO_BIT     5
`define UPSC_CTRL_SPK_BIT      6
`define UPSC_CTRL_TEST_BIT     7
`define UPSC_CTRL_RW_MASK      8'hE2
`define UPSC_CTRL_RESET        8'h20
`define UPSC_MODE_RST_BIT      0
`define UPSC_MODE_ACT_BIT      1
`define UPSC_MODE_LP_BIT       2
`define UPSC_STAT_PWR_BIT      6
`define UPSC_TIMING_RESET      8'h94
`define UPSC_TD_STEP_MS        100
`define UPSC_IDLE_STEP_MS      1000
`define UPSC_CLK_KHZ           100000
`define UPSC_SRST_CYCLES       4'h8
`endif

/* File: hw/upsc_delay_timer.v */
// step-unit countdown timer: runs (code+1) steps once started, then pulses done
// assumes clk 100 MHz, synchronous active-low reset; start restarts the count
`timescale 1ns/1ps
module upsc_delay_timer #(
	parameter STEP_CYCLES = 32'd10000000
) (
	input  wire       clk,
	input  wire       rst_b,
	input  wire       start,
	input  wire       stop,
	input  wire [3:0] code,
	output reg        done_ff
);
reg  [31:0] cyc_ff;
reg  [4:0]  steps_ff;
reg         run_ff;
wire        step_end = (cyc_ff == 32'h00000000);

always @(posedge clk)
begin
	if (!rst_b)
	begin
		cyc_ff   <= 32'h00000000;
		steps_ff <= 5'h00;
		run_ff   <= 1'b0;
		done_ff  <= 1'b0;
	end
	else if (start)
	begin
		cyc_ff   <= STEP_CYCLES - 32'h00000001;
		steps_ff <= {1'b0, code};
		run_ff   <= 1'b1;
		done_ff  <= 1'b0;
	end
	else if (stop || !run_ff)
	begin
		run_ff  <= 1'b0;
		done_ff <= 1'b0;
	end
	else if (step_end)
	begin
		cyc_ff <= STEP_CYCLES - 32'h00000001;
		if (steps_ff == 5'h00)
		begin
			run_ff  <= 1'b0;
			done_ff <= 1'b1;
		end
		else
			steps_ff <= steps_ff - 5'h01;
	end
	else
		cyc_ff <= cyc_ff - 32'h00000001;
end
endmodule // upsc_delay_timer

/* File: testbench/upsc_far_model.sv */
// far-side model: vendor test register data and power switch sense
// assumes the design muxes test data in only while test_sel is high
`timescale 1ns/1ps
module upsc_far_model (
	input  logic       clk,
	input  logic       test_sel,
	input  logic [7:0] reg_addr,
	input  logic       power_switch_on,
	output logic [7:0] test_rdata,
	output logic       power_switch_sense
);
	// unselected data keeps moving so stale bytes never match
	assign test_rdata = test_sel ? {4'hA, reg_addr[3:0]} : ~reg_addr;
	// the switch lags its control by a cycle, like the real transistor
	always @(posedge clk)
		power_switch_sense <= power_switch_on;
endmodule // upsc_far_model

/* File: testbench/upsc_regs_assertions.sv */
// port checker for the control and mode register group
// assumes it is bound to upsc_ctrl_regs and sees its ports only
`timescale 1ns/1ps
module upsc_regs_chk (
	input logic       clk,
	input logic       rst_b,
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic       reg_wr,
	input logic       reg_rd,
	input logic [7:0] reg_rdata_ff,
	input logic       test_sel,
	input logic       power_switch_sense,
	input logic       power_switch_on,
	input logic       left_speaker_to_dminus_switch,
	input logic       chip_soft_reset,
	input logic       identify_start,
	input logic       low_power_state,
	input logic       bus_voltage_present
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
////////////////////////////////
	test_window_a: assert property (test_sel |-> reg_addr inside {[8'h24:8'h26]})
		else $error("test select off window");
	ctrl_read_a: assert property (reg_rd && reg_addr == 8'h00 |=> !reg_rdata_ff[2]
		&& reg_rdata_ff[6] == $past(left_speaker_to_dminus_switch)) else $error("ctrl read");
	stat_read_a: assert property (reg_rd && reg_addr == 8'h03
		|=> reg_rdata_ff[6] == $past(power_switch_sense)) else $error("status read");
	mode_read_a: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata_ff[7:3] == 5'h00
		&& reg_rdata_ff[2] == $past(low_power_state)) else $error("mode read");
	srst_len_a: assert property ($rose(chip_soft_reset)
		|-> chip_soft_reset[*8] ##1 !chip_soft_reset) else $error("soft reset length");
	srst_cause_a: assert property ($rose(chip_soft_reset)
		|-> $past(reg_wr && reg_addr == 8'h00 && reg_wdata[2])) else $error("soft reset cause");
	srst_dflt_a: assert property ($fell(chip_soft_reset)
		|-> !left_speaker_to_dminus_switch && !low_power_state) else $error("soft reset value");
	ctrl_write_a: assert property (reg_wr && reg_addr == 8'h00 && !reg_wdata[2]
		&& !chip_soft_reset && !$past(chip_soft_reset) && $past(rst_b)
		&& !(bus_voltage_present && !$past(bus_voltage_present))
		|=> power_switch_on == $past(reg_wdata[1])) else $error("ctrl write");
	cover property (identify_start);
	cover property (chip_soft_reset ##1 !chip_soft_reset);
	cover property (test_sel && reg_rd);
endmodule // upsc_regs_chk
bind upsc_ctrl_regs upsc_regs_chk upsc_regs_chk_i (.*);

/* File: testbench/usb_port_switch_ctrl_mode_regs_bench.sv */
// self-checking bench for the control and mode register group
// assumes timer steps of 10 and 20 cycles and the far-side model
`timescale 1ns/1ps
module usb_port_switch_ctrl_mode_regs_bench;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff, test_rdata;
	logic clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, test_sel;
	logic bus_voltage_present = 1'h0, switch_activity = 1'h0, audio_tty_attached = 1'h0;
	logic power_switch_sense, power_switch_on, left_speaker_to_dminus_switch;
	logic chip_soft_reset, identify_start, low_power_state;
	int err_total = 0, n_tests = 0, n = 0;
	always #5 clk = ~clk;
	upsc_ctrl_regs #(.TD_STEP_CYCLES(10), .IDLE_STEP_CYCLES(20)) upsc_ctrl_regs_i (.*);
	upsc_far_model upsc_far_model_i (.*);
////////////////////////////////
	task chk(input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one access a call; a read compares against d
	task acc(input logic w, input logic [7:0] a, d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(posedge clk);
		#1 reg_wr = 1'h0;
		reg_rd = 1'h0;
		if (!w)
			chk(reg_rdata_ff, d);
		@(posedge clk);
		#1;
	endtask
	task print_verdict;
		$display("mismatches %0d, checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#20000;
		err_total++;
		print_verdict;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		#1 rst_b = 1'h1;
		acc(1'h0, 8'h00, 8'h20);
		acc(1'h0, 8'h01, 8'h94);
		acc(1'h0, 8'h02, 8'h01);
		acc(1'h0, 8'h02, 8'h00);
		acc(1'h1, 8'h02, 8'h04);
		acc(1'h0, 8'h02, 8'h00);
		acc(1'h1, 8'h01, 8'h14);
		audio_tty_attached = 1'h1;
		repeat (30) @(posedge clk);
		#1 chk(low_power_state, 1'h0);
		// a switch event restarts the (1+1)*20 cycle idle count
		switch_activity = 1'h1;
		@(posedge clk);
		#1 switch_activity = 1'h0;
		repeat (29) @(posedge clk);
		#1 chk(low_power_state, 1'h0);
		repeat (20) @(posedge clk);
		#1 chk(low_power_state, 1'h1);
		audio_tty_attached = 1'h0;
		switch_activity = 1'h1;
		@(posedge clk);
		#1 switch_activity = 1'h0;
		chk(low_power_state, 1'h0);
		bus_voltage_present = 1'h1;
		// identify fires (4+1)*10 cycles on; a few cycles of slack
		while (identify_start !== 1'h1 && n < 200)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk(n >= 48 && n <= 53, 1'h1);
		acc(1'h0, 8'h00, 8'h22);
		acc(1'h0, 8'h03, 8'h40);
		acc(1'h1, 8'h00, 8'hC0);
		acc(1'h0, 8'h00, 8'hC0);
		chk(left_speaker_to_dminus_switch, 1'h1);
		acc(1'h0, 8'h03, 8'h00);
		acc(1'h0, 8'h25, 8'hA5);
		acc(1'h1, 8'h02, 8'h00);
		acc(1'h1, 8'h02, 8'h06);
		acc(1'h0, 8'h02, 8'h06);
		acc(1'h1, 8'h00, 8'h20);
		acc(1'h0, 8'h25, 8'h00);
		bus_voltage_present = 1'h0;
		acc(1'h1, 8'h00, 8'h04);
		repeat (10) @(posedge clk);
		#1 acc(1'h0, 8'h00, 8'h20);
		acc(1'h0, 8'h01, 8'h94);
		acc(1'h0, 8'h02, 8'h01);
		print_verdict;
	end
endmodule // usb_port_switch_ctrl_mode_regs_bench
